//--- design/sie_top.sv
// Notes on behaviour
// - Reset held until supply good, then 200 ms
// - Falling edge on reset pin restarts timeout
// - Short external reset still gives full 200 ms
// - Manual reset low holds reset, plus timeout
// - Manual reset lows under 100 ns ignored
// - Reset aborts bus traffic, blocks memory access
// - Reset blocks new programming, running one finishes
// - Write protect high blocks array writes
// - START is SDA fall with SCL high
// - STOP is SDA rise with SCL high
// - SDA change during SCL high means START/STOP
// - Top address nibble matches device type
// - Address LSB one reads, zero writes
// - Matching address acknowledged in ninth clock
// - Write mode acknowledges word address and data
// - Read sends byte, continues only on ACK
// - STOP after write starts programming, device silent
// - Page write takes sixteen bytes, low bits increment
// - Extra page bytes wrap and overwrite earlier
// - Address NACKed while programming, ACKed afterwards
// - Write protect NACKs first data byte and every data byte after it
// - Address counter holds last plus one, wraps
// - Reads increment every address bit
// - Programming runs 5 ms, starting once the FIFO drains after STOP
module sie_top
  import sie_pkg::*;
#(
  parameter int unsigned RESET_TIMEOUT_CYC = sie_pkg::POWER_UP_RESET_TIMEOUT_CYC,
  parameter int unsigned PROG_TIME_CYC = sie_pkg::PROGRAM_CYCLE_TIME_CYC,
  parameter logic [3:0] DEVICE_TYPE = sie_pkg::DEVICE_TYPE_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Supervisor inputs
  input wire logic supply_ok_in,
  input wire logic manual_reset_n_in,
  // Reset pin, open drain, also an input
  input wire logic reset_pin_n_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n_out,
  output logic reset_high_out,
  // Write protect
  input wire logic write_protect_in,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Status
  output logic prog_busy_out
);
  import sie_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [5:0] sync1_reg; // First stage, read only by second stage
  logic [5:0] sync2_reg; // Second stage, safe to use
  logic scl_s, sda_s, wp_s, supply_s, mr_s, pin_s;
  logic scl_d_reg; // Previous SCL for edges
  logic sda_d_reg; // Previous SDA for edges
  logic pin_d_reg; // Previous reset pin level
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [2:0] mr_cnt_reg; // Manual reset low duration
  logic mr_low; // Filtered manual reset
  logic pin_fall; // External falling edge on reset pin
  logic hold_reset; // A level cause of reset is present
  logic reset_active_reg; // Supervisor reset state
  logic [RESET_CNT_W-1:0] rst_cnt_reg; // Timeout counter
  logic drive_low_reg; // Constant low level for open drain pins
  logic rst_oe_n_reg; // Reset pin enable, low drives
  logic rst_high_reg; // Active high reset output
  sie_state_t state_reg; // Bus engine state
  sie_state_t ack_next_reg; // State after the ACK clock
  logic [1:0] kind_reg; // Which byte is being received
  logic [3:0] bit_cnt_reg; // Bits received or sent
  logic [7:0] rx_shift_reg; // Incoming byte
  logic [7:0] tx_shift_reg; // Outgoing byte
  logic [7:0] addr_reg; // Address counter
  logic sda_rel_reg; // High releases SDA
  logic master_ack_reg; // Master ACK sampled in read
  logic data_seen_reg; // Data bytes queued this write
  logic byte_done; // Eighth bit finished on SCL fall
  logic push_data; // Data byte accepted into FIFO
  logic stop_write; // STOP ending a write with data
  logic fifo_in_ready, fifo_out_valid;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic prog_pending_reg; // Programming waits for FIFO to drain
  logic prog_busy_reg; // Internal programming running
  logic [PROG_CNT_W-1:0] prog_cnt_reg; // Programming time counter
  logic commit; // Last cycle of programming
  logic write_busy; // Device must not answer its address
  logic [7:0] mem [MEM_BYTES]; // Array contents
  logic [7:0] page_data [PAGE_BYTES]; // Page buffer
  logic [PAGE_BYTES-1:0] page_mask_reg; // Page bytes to program
  logic [3:0] page_base_reg; // Upper address of the page
  logic [7:0] mem_rdata;

  // In-page increment: upper nibble fixed, lower nibble wraps
  function automatic logic [7:0] page_inc(input logic [7:0] a);
    page_inc = {a[7:4], a[3:0] + 4'h1};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {reset_pin_n_in, manual_reset_n_in, supply_ok_in, write_protect_in, sda_in, scl_in};
      sync2_reg <= sync1_reg;
    end
  end
  assign {pin_s, mr_s, supply_s, wp_s, sda_s, scl_s} = sync2_reg;

  // Edge history of the synchronised lines
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      pin_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      pin_d_reg <= pin_s;
    end
  end
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  // Any SDA move while SCL stays high is a condition, never data
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Supervisor
  // Manual reset counts as low only after a full glitch window
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mr_cnt_reg <= '0;
    end else if (mr_s) begin
      mr_cnt_reg <= '0;
    end else if (mr_cnt_reg != MR_GLITCH_LAST) begin
      mr_cnt_reg <= mr_cnt_reg + 3'h1;
    end
  end
  assign mr_low = (mr_cnt_reg == MR_GLITCH_LAST);
  // Our own drive pulls the pin low too, so edges are only taken while released
  assign pin_fall = pin_d_reg && !pin_s && rst_oe_n_reg;
  assign hold_reset = !supply_s || mr_low;

  // Timeout restarts on every cause, releases after the full count
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_active_reg <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (hold_reset || pin_fall) begin
      reset_active_reg <= 1'b1;
      rst_cnt_reg <= '0;
    end else if (reset_active_reg) begin
      if (rst_cnt_reg == RESET_CNT_W'(RESET_TIMEOUT_CYC - 1)) begin
        reset_active_reg <= 1'b0;
      end else begin
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      end
    end
  end

  // Registered reset outputs, one cycle behind the state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_low_reg <= 1'b0;
      rst_oe_n_reg <= 1'b0;
      rst_high_reg <= 1'b1;
    end else begin
      drive_low_reg <= 1'b0;
      rst_oe_n_reg <= !reset_active_reg;
      rst_high_reg <= reset_active_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus engine
  assign byte_done = (state_reg == ST_RECV) && scl_fall && (bit_cnt_reg == 4'h8);
  assign write_busy = prog_busy_reg || prog_pending_reg;
  // FIFO full is answered with NACK since SCL cannot be stretched here
  assign push_data = byte_done && (kind_reg == KIND_DATA) && !wp_s && fifo_in_ready
    && !reset_active_reg && !start_det && !stop_det;
  assign stop_write = stop_det && data_seen_reg && !reset_active_reg;
  assign mem_rdata = mem[addr_reg];

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_IDLE;
      ack_next_reg <= ST_IDLE;
      kind_reg <= KIND_ADDR;
      bit_cnt_reg <= '0;
      rx_shift_reg <= '0;
      tx_shift_reg <= '0;
      addr_reg <= '0;
      sda_rel_reg <= 1'b1;
      master_ack_reg <= 1'b0;
      data_seen_reg <= 1'b0;
    end else if (reset_active_reg) begin
      state_reg <= ST_IDLE;
      sda_rel_reg <= 1'b1;
      data_seen_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_RECV;
      kind_reg <= KIND_ADDR;
      bit_cnt_reg <= '0;
      sda_rel_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_rel_reg <= 1'b1;
      data_seen_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RECV: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= '0;
            if (kind_reg == KIND_ADDR) begin
              // Silent during programming so polling sees NACK
              if (rx_shift_reg[7:4] == DEVICE_TYPE && !write_busy) begin
                sda_rel_reg <= 1'b0;
                state_reg <= ST_ACK;
                ack_next_reg <= rx_shift_reg[0] ? ST_SEND : ST_RECV;
                kind_reg <= KIND_WORD;
              end else begin
                state_reg <= ST_WAIT;
              end
            end else if (kind_reg == KIND_WORD) begin
              sda_rel_reg <= 1'b0;
              addr_reg <= rx_shift_reg;
              state_reg <= ST_ACK;
              ack_next_reg <= ST_RECV;
              kind_reg <= KIND_DATA;
            end else if (push_data) begin
              sda_rel_reg <= 1'b0;
              addr_reg <= page_inc(addr_reg);
              data_seen_reg <= 1'b1;
              state_reg <= ST_ACK;
              ack_next_reg <= ST_RECV;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (ack_next_reg == ST_SEND) begin
              tx_shift_reg <= mem_rdata;
              sda_rel_reg <= mem_rdata[7];
              addr_reg <= addr_reg + 8'h01;
              state_reg <= ST_SEND;
            end else begin
              sda_rel_reg <= 1'b1;
              state_reg <= ack_next_reg;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              bit_cnt_reg <= '0;
              sda_rel_reg <= 1'b1;
              state_reg <= ST_MACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              sda_rel_reg <= tx_shift_reg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            master_ack_reg <= !sda_s;
          end else if (scl_fall) begin
            if (master_ack_reg) begin
              tx_shift_reg <= mem_rdata;
              sda_rel_reg <= mem_rdata[7];
              addr_reg <= addr_reg + 8'h01;
              state_reg <= ST_SEND;
            end else begin
              state_reg <= ST_WAIT;
            end
          end
        end
        default: begin
          // Idle and wait: bus ignored until the next condition
          sda_rel_reg <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data FIFO; draining stalls while the page is being programmed
  sie_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .flush_in(reset_active_reg),
    .in_valid_in(push_data),
    .in_ready_out(fifo_in_ready),
    .in_data_in({addr_reg, rx_shift_reg}),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(!prog_busy_reg),
    .out_data_out(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Page buffer and programming cycle
  assign commit = prog_busy_reg && (prog_cnt_reg == PROG_CNT_W'(PROG_TIME_CYC - 1));

  // Page buffer bytes; later bytes at a wrapped address overwrite earlier
  always_ff @(posedge clk_in) begin
    if (fifo_out_valid && !prog_busy_reg) begin
      page_data[fifo_out_data[11:8]] <= fifo_out_data[7:0];
    end
  end

  // Which page bytes are pending, cleared by commit or abort
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      page_mask_reg <= '0;
      page_base_reg <= '0;
    end else if (commit || (reset_active_reg && !prog_busy_reg)) begin
      page_mask_reg <= '0;
    end else if (fifo_out_valid && !prog_busy_reg) begin
      page_mask_reg[fifo_out_data[11:8]] <= 1'b1;
      page_base_reg <= fifo_out_data[15:12];
    end
  end

  // Start after STOP once queued bytes are in the page; reset cancels a start
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_pending_reg <= 1'b0;
      prog_busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else begin
      if (reset_active_reg) begin
        prog_pending_reg <= 1'b0;
      end else if (stop_write) begin
        prog_pending_reg <= 1'b1;
      end else if (prog_pending_reg && !fifo_out_valid) begin
        prog_pending_reg <= 1'b0;
        prog_busy_reg <= 1'b1;
        prog_cnt_reg <= '0;
      end
      // A running cycle ignores reset and always finishes
      if (prog_busy_reg) begin
        if (commit) begin
          prog_busy_reg <= 1'b0;
        end else begin
          prog_cnt_reg <= prog_cnt_reg + 1'b1;
        end
      end
    end
  end

  // All received page bytes land in the array at once
  always_ff @(posedge clk_in) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_mask_reg[i]) begin
          mem[{page_base_reg, 4'(i)}] <= page_data[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reset_pin_out = drive_low_reg;
  assign reset_pin_oe_n_out = rst_oe_n_reg;
  assign reset_high_out = rst_high_reg;
  assign sda_out = drive_low_reg;
  assign sda_oe_n_out = sda_rel_reg;
  assign prog_busy_out = prog_busy_reg;
endmodule // sie_top

//--- design/sie_pkg.sv
package sie_pkg;
  // Core clock and derived time bases
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int CLK_PERIOD_NS = 25;
  // Supervisor timeout after the last reset cause
  localparam int POWER_UP_RESET_TIMEOUT_MS = 200;
  localparam int POWER_UP_RESET_TIMEOUT_CYC = POWER_UP_RESET_TIMEOUT_MS * CLK_FREQ_KHZ;
  localparam int RESET_CNT_W = 23;
  // Manual reset glitch immunity, rounded up to whole cycles
  localparam int MR_GLITCH_NS = 100;
  localparam int MR_GLITCH_CYC = (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] MR_GLITCH_LAST = 3'(MR_GLITCH_CYC);
  // Internal programming cycle, longest time rounds down
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int PROGRAM_CYCLE_TIME_CYC = PROGRAM_CYCLE_TIME_MS * CLK_FREQ_KHZ;
  localparam int PROG_CNT_W = 18;
  // Memory organisation
  localparam int MEM_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'hA;
  // Data FIFO between the bus receiver and the page buffer
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;
  // Synchroniser order {rst_pin, mr, supply, wp, sda, scl} and reset values
  localparam logic [5:0] SYNC_RESET = 6'h33;
  // Byte kinds inside a transaction
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_WORD = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  // Bus engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RECV = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_SEND = 6'b001000,
    ST_MACK = 6'b010000,
    ST_WAIT = 6'b100000
  } sie_state_t;
endpackage

//--- design/sie_fifo.sv
module sie_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH]; // Word storage, no reset needed
  logic [PW-1:0] wr_ptr_reg; // Next slot to fill
  logic [PW-1:0] rd_ptr_reg; // Next slot to drain
  logic [PW:0] count_reg; // Words held
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = store[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out && !flush_in;
  assign pop = out_valid_out && out_ready_in && !flush_in;

  // Storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers and fill level; flush drops everything held
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // sie_fifo

//--- bench/sie_props.sv
module sie_props #(
  parameter int unsigned RESET_TIMEOUT_CYC = 200,
  parameter int unsigned PROG_TIME_CYC = 300
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Supervisor
  input wire logic supply_ok_in,
  input wire logic manual_reset_n_in,
  input wire logic reset_pin_n_in,
  input wire logic reset_pin_oe_n_out,
  input wire logic reset_high_out,
  // Bus and status
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic prog_busy_out
);
  int unsigned quiet_reg; // Cycles since the last reset cause
  int unsigned prog_reg; // Cycles of the running program cycle
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////
  // Raw causes lead the design's synchronisers, so this count errs early
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      quiet_reg <= 0;
    end else if (!supply_ok_in || !manual_reset_n_in || ($fell(reset_pin_n_in) && reset_pin_oe_n_out)) begin
      quiet_reg <= 0;
    end else if (quiet_reg < RESET_TIMEOUT_CYC + 20) begin
      quiet_reg <= quiet_reg + 1;
    end
  end
  // Length of the programming cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_reg <= 0;
    end else begin
      prog_reg <= prog_busy_out ? prog_reg + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_reset_pair: assert property (reset_high_out == !reset_pin_oe_n_out)
    else $error("reset outputs disagree");
  a_release_late: assert property ($rose(reset_pin_oe_n_out) |-> quiet_reg >= RESET_TIMEOUT_CYC)
    else $error("reset released before the timeout");
  a_release_due: assert property (quiet_reg == RESET_TIMEOUT_CYC + 12 |-> reset_pin_oe_n_out)
    else $error("reset not released after the timeout");
  a_quiet_in_reset: assert property ((!reset_pin_oe_n_out) [*3] |-> sda_oe_n_out)
    else $error("data line driven during reset");
  a_no_prog_start: assert property ($rose(prog_busy_out) |-> reset_pin_oe_n_out)
    else $error("programming started in reset");
  a_prog_length: assert property ($fell(prog_busy_out) |-> prog_reg == PROG_TIME_CYC)
    else $error("programming cycle length wrong");
  a_silent_busy: assert property (prog_busy_out |-> sda_oe_n_out)
    else $error("device answered while programming");
  a_stable_high: assert property ($rose(scl_in) && reset_pin_oe_n_out |-> ##1 $stable(sda_oe_n_out) [*3])
    else $error("data drive changed while clock high");
endmodule // sie_props

bind sie_top sie_props #(.RESET_TIMEOUT_CYC(RESET_TIMEOUT_CYC), .PROG_TIME_CYC(PROG_TIME_CYC)) u_props (
  .clk_in, .reset_n_in, .supply_ok_in, .manual_reset_n_in, .reset_pin_n_in, .reset_pin_oe_n_out,
  .reset_high_out, .scl_in, .sda_oe_n_out, .prog_busy_out
);

//--- bench/sie_master.sv
module sie_master (
  // Bus lines driven by the master, open drain on data
  output logic scl_out,
  output logic sda_oe_n_out,
  // Resolved data wire
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands high between frames, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  // Data set mid-low, sampled mid-high, never moved while clock high
  // Lines move by non-blocking update so a clock edge at the same time never races them
  task automatic bit_slot(input logic b, output logic s);
    sda_oe_n_out <= b;
    #50;
    scl_out <= 1'b1;
    #50;
    s = sda_in;
    #50;
    scl_out <= 1'b0;
    #50;
  endtask
  // Clock rises late so a slave's acknowledge has been let go first
  task automatic start();
    sda_oe_n_out <= 1'b1;
    #100;
    scl_out <= 1'b1;
    #100;
    sda_oe_n_out <= 1'b0;
    #100;
    scl_out <= 1'b0;
    #50;
  endtask
  task automatic stop();
    sda_oe_n_out <= 1'b0;
    #100;
    scl_out <= 1'b1;
    #100;
    sda_oe_n_out <= 1'b1;
    #100;
  endtask
  // Byte out, then the slave's acknowledge in the ninth clock
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask
  // Byte in, then our acknowledge or its absence
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(nack, s);
  endtask
endmodule // sie_master

//--- bench/tb_sie_top.sv
module tb_sie_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sie_pkg::*;
  localparam int RT = 200; // Shortened reset timeout
  localparam int PT = 300; // Shortened programming time
  logic clk_in, reset_n_in, supply_ok_in, manual_reset_n_in, write_protect_in, ext_rst_low;
  logic scl, m_oe_n, reset_pin_oe_n_out, reset_high_out, sda_oe_n_out, prog_busy_out, sda_lvl, rp_lvl;
  logic [15:0] lfsr_reg; // Random source
  logic [7:0] mem [256]; // Array model
  int failures, cmp_count;
  // Wires with pull-ups; an enabled device driver puts its own level on the wire
  wire logic sda_wire = !m_oe_n ? 1'b0 : (!sda_oe_n_out ? sda_lvl : 1'b1);
  wire logic rp_wire = ext_rst_low ? 1'b0 : (!reset_pin_oe_n_out ? rp_lvl : 1'b1);
  ////////////////////////////////////////////////////////////////////////
  sie_top #(.RESET_TIMEOUT_CYC(RT), .PROG_TIME_CYC(PT)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .supply_ok_in(supply_ok_in),
    .manual_reset_n_in(manual_reset_n_in), .reset_pin_n_in(rp_wire), .reset_pin_out(rp_lvl),
    .reset_pin_oe_n_out(reset_pin_oe_n_out), .reset_high_out(reset_high_out),
    .write_protect_in(write_protect_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_lvl),
    .sda_oe_n_out(sda_oe_n_out), .prog_busy_out(prog_busy_out)
  );
  sie_master m (.scl_out(scl), .sda_oe_n_out(m_oe_n), .sda_in(sda_wire));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait on reset release (sel 0) or busy (sel 1)
  task automatic wait_for(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while ((sel ? prog_busy_out : reset_pin_oe_n_out) !== lvl) begin
      @(negedge clk_in);
      n++;
      if (n > lim) begin
        failures++;
        close_out();
      end
    end
  endtask
  // Write n random bytes from address a; protected writes expect NACK on every data byte
  task automatic wr(input logic [7:0] a, input int n, input logic wp_on);
    logic ack;
    logic [7:0] d;
    m.start();
    m.wbyte({DEVICE_TYPE_DEFAULT, 4'h0}, ack);
    check(ack, 1'b1);
    m.wbyte(a, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      d = lfsr_reg[7:0];
      m.wbyte(d, ack);
      check(ack, !wp_on);
      if (!wp_on) mem[{a[7:4], a[3:0] + 4'(i)}] = d;
    end
    m.stop();
  endtask
  // Dummy write of the address, repeated start, sequential read
  task automatic rd(input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] d;
    m.start();
    m.wbyte({DEVICE_TYPE_DEFAULT, 4'h0}, ack);
    m.wbyte(a, ack);
    m.start();
    m.wbyte({DEVICE_TYPE_DEFAULT, 4'h1}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i == n - 1, d);
      check(d, mem[8'(a + i)]);
    end
    m.stop();
  endtask
  task automatic poll(input logic exp);
    logic ack;
    m.start();
    m.wbyte({DEVICE_TYPE_DEFAULT, 4'h0}, ack);
    check(ack, exp);
    m.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [7:0] pb, rb;
    logic ack;
    {reset_n_in, supply_ok_in, write_protect_in, ext_rst_low} = 4'h0;
    manual_reset_n_in = 1'b1;
    lfsr_reg = 16'h6843;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    check(reset_pin_oe_n_out, 1'b0);
    supply_ok_in <= 1'b1;
    wait_for(0, 1'b1, RT + 40, n);
    check(n >= RT && n <= RT + 12, 1'b1);
    repeat (4) @(posedge clk_in);
    lfsr_reg = lfsr_next(lfsr_reg);
    pb = {lfsr_reg[7:4], 4'h0};
    // Byte write just past the page, polled while busy
    wr(pb + 8'h10, 1, 1'b0);
    poll(1'b0);
    check(prog_busy_out, 1'b1);
    wait_for(1, 1'b0, PT + 20, n);
    poll(1'b1);
    // Page write of 18 bytes wraps inside the page
    wr({pb[7:4], lfsr_reg[11:8]}, 18, 1'b0);
    wait_for(1, 1'b0, PT + 20, n);
    rd(pb, 17);
    // Wrong device type is ignored
    m.start();
    m.wbyte({~DEVICE_TYPE_DEFAULT, 4'h0}, ack);
    check(ack, 1'b0);
    m.stop();
    // Protected write leaves the array alone
    write_protect_in <= 1'b1;
    wr(pb, 1, 1'b1);
    repeat (10) @(posedge clk_in);
    check(prog_busy_out, 1'b0);
    write_protect_in <= 1'b0;
    rd(pb, 1);
    // Current-address read picks up one past the byte just read
    m.start();
    m.wbyte({DEVICE_TYPE_DEFAULT, 4'h1}, ack);
    m.rbyte(1'b1, rb);
    check(rb, mem[8'(pb + 1)]);
    m.stop();
    // Short manual low is filtered, long one resets
    manual_reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    manual_reset_n_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    check(reset_pin_oe_n_out, 1'b1);
    manual_reset_n_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    check(reset_pin_oe_n_out, 1'b0);
    manual_reset_n_in <= 1'b1;
    wait_for(0, 1'b1, RT + 40, n);
    check(n >= RT, 1'b1);
    // Brief external pull on the reset wire still gives a full timeout
    repeat (4) @(posedge clk_in);
    ext_rst_low <= 1'b1;
    repeat (10) @(posedge clk_in);
    ext_rst_low <= 1'b0;
    repeat (20) @(posedge clk_in);
    check(reset_pin_oe_n_out, 1'b0);
    wait_for(0, 1'b1, RT + 40, n);
    check(n >= RT - 40, 1'b1);
    // Supply loss mid-programming: bus refused, write still lands
    repeat (4) @(posedge clk_in);
    wr(pb, 1, 1'b0);
    wait_for(1, 1'b1, 20, n);
    @(posedge clk_in);
    supply_ok_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    poll(1'b0);
    wait_for(1, 1'b0, PT + 20, n);
    @(posedge clk_in);
    supply_ok_in <= 1'b1;
    wait_for(0, 1'b1, RT + 40, n);
    repeat (4) @(posedge clk_in);
    rd(pb, 1);
    close_out();
  end
endmodule // tb_sie_top
